// file: supmon_config_regs.sv
`timescale 1ns/1ns
// How it works
// - Bipolar high band: five bits, upper reserved
// - Bipolar low band: five bits, upper reserved
// - Low limit: full byte, read/write, resets zero
// - High-voltage high limit: byte, resets all ones
// - High-voltage bands: five bits each, upper reserved
// - Select bits 6-4 pick deglitch delay
// - Bipolar bit 7 sign; negative ignores span
// - Bipolar select resets to all zeros
// - Window kind: either limit raises the fault
// - Deglitch drops short pulses, delays long ones
// - Negative mode uses fixed -6 to -2 span
module supmon_config_regs
#(
	parameter int CYC_PER_US = supmon_pkg::CYC_PER_US
)
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	output logic reg_ack_q,
	input wire logic [2:0] over_raw,
	input wire logic [2:0] under_raw,
	output supmon_pkg::supmon_cfg_s cfg_q [supmon_pkg::MON_COUNT],
	output logic [7:0] hv_high_limit_q,
	output supmon_pkg::supmon_span_e span_q [supmon_pkg::MON_COUNT],
	output logic [2:0] fault_q
);

	supmon_pkg::supmon_cfg_s cfg_d [supmon_pkg::MON_COUNT];
	supmon_pkg::supmon_span_e span_d [supmon_pkg::MON_COUNT];
	logic [7:0] hv_high_limit_d;
	logic [7:0] reg_rdata_d;
	logic hv_written_q;
	logic hv_written_d;
	logic [2:0] pick;
	logic [15:0] hold [supmon_pkg::MON_COUNT];

	// Address of one register of one monitor
	function automatic logic [7:0] mon_addr(int mon, int reg_no);
		logic [7:0] a;
		a = 8'h0000;
		unique case (mon)
			0: a = (reg_no == 1) ? supmon_pkg::OFS_BIP_A_HIGH_BAND : (reg_no == 2) ? supmon_pkg::OFS_BIP_A_LOW_LIMIT :
				(reg_no == 3) ? supmon_pkg::OFS_BIP_A_LOW_BAND : supmon_pkg::OFS_BIP_A_SELECT;
			1: a = (reg_no == 1) ? supmon_pkg::OFS_BIP_B_HIGH_BAND : (reg_no == 2) ? supmon_pkg::OFS_BIP_B_LOW_LIMIT :
				(reg_no == 3) ? supmon_pkg::OFS_BIP_B_LOW_BAND : supmon_pkg::OFS_BIP_B_SELECT;
			default: a = (reg_no == 1) ? supmon_pkg::OFS_HV_HIGH_BAND : (reg_no == 2) ? supmon_pkg::OFS_HV_LOW_LIMIT :
				(reg_no == 3) ? supmon_pkg::OFS_HV_LOW_BAND : supmon_pkg::OFS_HV_SELECT;
		endcase
		return a;
	endfunction : mon_addr

	// Select byte as software reads it; reserved bits read zero
	function automatic logic [7:0] sel_byte(supmon_pkg::supmon_cfg_s c);
		logic [7:0] b;
		b = 8'h0000;
		b[supmon_pkg::SEL_SIGN_BIT] = c.sign_choice;
		b[supmon_pkg::SEL_DELAY_HI:supmon_pkg::SEL_DELAY_LO] = c.deglitch_delay_choice;
		b[supmon_pkg::SEL_SPAN_BIT] = c.span_choice;
		b[supmon_pkg::SEL_KIND_HI:supmon_pkg::SEL_KIND_LO] = c.fault_kind_choice;
		return b;
	endfunction : sel_byte

	// Register writes; only defined bits are stored
	always_comb
	begin
		hv_high_limit_d = hv_high_limit_q;
		hv_written_d = hv_written_q;
		if (reg_wr && reg_addr == supmon_pkg::OFS_HV_HIGH_LIMIT)
		begin
			hv_high_limit_d = reg_wdata;
			hv_written_d = 1'b1;
		end
		for (int m = 0; m < supmon_pkg::MON_COUNT; m++)
		begin
			cfg_d[m] = cfg_q[m];
			if (reg_wr && reg_addr == mon_addr(m, 1))
				cfg_d[m].high_band_code = reg_wdata[supmon_pkg::BAND_HI:0];
			if (reg_wr && reg_addr == mon_addr(m, 2))
				cfg_d[m].low_limit_code = reg_wdata;
			if (reg_wr && reg_addr == mon_addr(m, 3))
				cfg_d[m].low_band_code = reg_wdata[supmon_pkg::BAND_HI:0];
			if (reg_wr && reg_addr == mon_addr(m, 4))
			begin
				// Bit 7 and bit 3 are reserved on the high-voltage monitor
				cfg_d[m].sign_choice = (m == supmon_pkg::MON_HV) ? 1'b0 : reg_wdata[supmon_pkg::SEL_SIGN_BIT];
				cfg_d[m].deglitch_delay_choice = reg_wdata[supmon_pkg::SEL_DELAY_HI:supmon_pkg::SEL_DELAY_LO];
				cfg_d[m].span_choice = reg_wdata[supmon_pkg::SEL_SPAN_BIT];
				cfg_d[m].fault_kind_choice = reg_wdata[supmon_pkg::SEL_KIND_HI:supmon_pkg::SEL_KIND_LO];
			end
		end
	end

	// Span decode; sign wins over span bit on bipolar monitors
	always_comb
	begin
		for (int m = 0; m < supmon_pkg::MON_COUNT; m++)
		begin
			if (m == supmon_pkg::MON_HV)
				span_d[m] = cfg_d[m].span_choice ? supmon_pkg::SPAN_4P8_TO_14P4 : supmon_pkg::SPAN_2_TO_6;
			else if (cfg_d[m].sign_choice)
				span_d[m] = supmon_pkg::SPAN_NEG_6_TO_2;
			else
				span_d[m] = cfg_d[m].span_choice ? supmon_pkg::SPAN_2_TO_6 : supmon_pkg::SPAN_1_TO_3;
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		reg_rdata_d = 8'h0000;
		if (reg_addr == supmon_pkg::OFS_HV_HIGH_LIMIT)
			reg_rdata_d = hv_high_limit_q;
		for (int m = 0; m < supmon_pkg::MON_COUNT; m++)
		begin
			if (reg_addr == mon_addr(m, 1))
				reg_rdata_d = {3'h0, cfg_q[m].high_band_code};
			if (reg_addr == mon_addr(m, 2))
				reg_rdata_d = cfg_q[m].low_limit_code;
			if (reg_addr == mon_addr(m, 3))
				reg_rdata_d = {3'h0, cfg_q[m].low_band_code};
			if (reg_addr == mon_addr(m, 4))
				reg_rdata_d = sel_byte(cfg_q[m]);
		end
	end

	// All setup registers; power-on values are constants
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int m = 0; m < supmon_pkg::MON_COUNT; m++)
			begin
				cfg_q[m].low_limit_code <= supmon_pkg::RST_LOW_LIMIT;
				cfg_q[m].high_band_code <= supmon_pkg::RST_BAND;
				cfg_q[m].low_band_code <= supmon_pkg::RST_BAND;
				cfg_q[m].sign_choice <= supmon_pkg::RST_SIGN;
				cfg_q[m].deglitch_delay_choice <= supmon_pkg::RST_DELAY;
				cfg_q[m].span_choice <= supmon_pkg::RST_SPAN;
				cfg_q[m].fault_kind_choice <= supmon_pkg::RST_KIND;
				span_q[m] <= (m == supmon_pkg::MON_HV) ? supmon_pkg::SPAN_2_TO_6 : supmon_pkg::SPAN_1_TO_3;
			end
			hv_high_limit_q <= supmon_pkg::RST_HV_HIGH_LIMIT;
			hv_written_q <= 1'b0;
			reg_rdata_q <= 8'h0000;
			reg_ack_q <= 1'b0;
		end
		else
		begin
			for (int m = 0; m < supmon_pkg::MON_COUNT; m++)
			begin
				cfg_q[m] <= cfg_d[m];
				span_q[m] <= span_d[m];
			end
			hv_high_limit_q <= hv_high_limit_d;
			hv_written_q <= hv_written_d;
			reg_rdata_q <= reg_rd ? reg_rdata_d : reg_rdata_q;
			reg_ack_q <= reg_rd;
		end
	end

	// Fault path per monitor: kind pick, then deglitch
	for (genvar g = 0; g < supmon_pkg::MON_COUNT; g++)
	begin : g_mon
		assign hold[g] = supmon_pkg::supmon_dly_cycles(cfg_q[g].deglitch_delay_choice, CYC_PER_US);

		supmon_fault_pick u_pick
		(
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.over_raw(over_raw[g]),
			.under_raw(under_raw[g]),
			.fault_kind_choice(cfg_q[g].fault_kind_choice),
			.pick_q(pick[g])
		);

		supmon_deglitch u_deglitch
		(
			.clk_sys(clk_sys),
			.arst_n(arst_n),
			.level_in(pick[g]),
			.hold_cycles(hold[g]),
			.level_q(fault_q[g])
		);
	end

	band_reserved_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && (reg_addr == supmon_pkg::OFS_BIP_A_HIGH_BAND || reg_addr == supmon_pkg::OFS_BIP_B_LOW_BAND)
		|=> reg_ack_q && (reg_rdata_q[7:5] == 3'h0))
		else $error("band reserved bits read nonzero");

	hv_band_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_HV_LOW_BAND
		|=> cfg_q[supmon_pkg::MON_HV].low_band_code == $past(reg_wdata[4:0]))
		else $error("high-voltage low band not stored");

	low_limit_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_B_LOW_LIMIT ##1 !reg_wr
		##1 reg_rd && reg_addr == supmon_pkg::OFS_BIP_B_LOW_LIMIT |=> reg_rdata_q == $past(reg_wdata, 3))
		else $error("low limit readback mismatch");

	hv_limit_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!hv_written_q |-> hv_high_limit_q == 8'h00FF)
		else $error("high-voltage limit lost power-on value");

	neg_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_A_SELECT && reg_wdata[7]
		|=> span_q[0] == supmon_pkg::SPAN_NEG_6_TO_2)
		else $error("negative mode span wrong");

	pos_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!cfg_q[1].sign_choice |-> span_q[1] == (cfg_q[1].span_choice ? supmon_pkg::SPAN_2_TO_6 : supmon_pkg::SPAN_1_TO_3))
		else $error("bipolar span decode wrong");

	hv_sign_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_HV_SELECT |=> !cfg_q[supmon_pkg::MON_HV].sign_choice)
		else $error("high-voltage sign bit stored");

	delay_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[0].deglitch_delay_choice == 3'h6 |-> hold[0] == 16'(supmon_pkg::DLY_US_6 * CYC_PER_US))
		else $error("deglitch hold count wrong");

	// Stored fields follow the written byte; reads show the old value
	bip_high_band_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_A_HIGH_BAND
		|=> cfg_q[0].high_band_code == $past(reg_wdata[4:0]))
		else $error("bipolar high band not stored");

	bip_b_band_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_B_HIGH_BAND
		|=> cfg_q[1].high_band_code == $past(reg_wdata[4:0]))
		else $error("second bipolar high band not stored");

	bip_low_band_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_A_LOW_BAND
		|=> cfg_q[0].low_band_code == $past(reg_wdata[4:0]))
		else $error("bipolar low band not stored");

	low_band_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && (reg_addr == supmon_pkg::OFS_BIP_A_LOW_BAND || reg_addr == supmon_pkg::OFS_BIP_B_LOW_BAND)
		|=> reg_rdata_q[7:5] == 3'h0)
		else $error("low band reserved bits read nonzero");

	low_limit_store_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_A_LOW_LIMIT
		|=> cfg_q[0].low_limit_code == $past(reg_wdata))
		else $error("bipolar low limit not stored");

	hv_limit_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_HV_HIGH_LIMIT
		|=> hv_high_limit_q == $past(reg_wdata))
		else $error("high-voltage limit not stored");

	hv_band_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_rd && reg_addr == supmon_pkg::OFS_HV_HIGH_BAND
		|=> reg_rdata_q == {3'h0, $past(cfg_q[supmon_pkg::MON_HV].high_band_code)})
		else $error("high-voltage high band read wrong");

	delay_store_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_B_SELECT
		|=> cfg_q[1].deglitch_delay_choice == $past(reg_wdata[6:4]))
		else $error("deglitch delay not stored");

	hv_hold_long_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[supmon_pkg::MON_HV].deglitch_delay_choice == 3'h7
		|-> hold[supmon_pkg::MON_HV] == 16'(supmon_pkg::DLY_US_7 * CYC_PER_US))
		else $error("high-voltage hold count wrong");

	sign_store_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_BIP_B_SELECT
		|=> cfg_q[1].sign_choice == $past(reg_wdata[7]))
		else $error("bipolar sign not stored");

	neg_keeps_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[0].sign_choice
		|-> span_q[0] == supmon_pkg::SPAN_NEG_6_TO_2)
		else $error("negative mode did not ignore span bit");

	sel_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		$rose(arst_n)
		|-> sel_byte(cfg_q[0]) == 8'h00 && sel_byte(cfg_q[1]) == 8'h00)
		else $error("bipolar select not zero after reset");

	kind_store_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		reg_wr && reg_addr == supmon_pkg::OFS_HV_SELECT
		|=> cfg_q[supmon_pkg::MON_HV].fault_kind_choice == $past(reg_wdata[1:0]))
		else $error("high-voltage fault kind not stored");

	under_kind_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[1].fault_kind_choice == 2'h1
		|=> pick[1] == $past(under_raw[1]))
		else $error("under-limit kind picked wrong result");

	hv_span_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[supmon_pkg::MON_HV].span_choice
		|-> span_q[supmon_pkg::MON_HV] == supmon_pkg::SPAN_4P8_TO_14P4)
		else $error("high-voltage upper span wrong");

	no_hold_pass_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q[supmon_pkg::MON_HV].deglitch_delay_choice == 3'h0 && pick[supmon_pkg::MON_HV] != fault_q[supmon_pkg::MON_HV]
		|=> fault_q[supmon_pkg::MON_HV] == $past(pick[supmon_pkg::MON_HV]))
		else $error("zero delay fault did not follow");

endmodule : supmon_config_regs

// file: supmon_deglitch.sv
`timescale 1ns/1ns
// Passes a level only once it has held for the programmed cycles
module supmon_deglitch
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic level_in,
	input wire logic [15:0] hold_cycles,
	output logic level_q
);

	logic level_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;

	// A change shorter than the hold is dropped and the count restarts
	always_comb
	begin
		level_d = level_q;
		cnt_d = 16'h0000;
		if (level_in != level_q)
		begin
			if (cnt_q + 16'h0001 >= hold_cycles)
				level_d = level_in;
			else
				cnt_d = cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			level_q <= 1'b0;
			cnt_q <= 16'h0000;
		end
		else
		begin
			level_q <= level_d;
			cnt_q <= cnt_d;
		end
	end

	// Output moves only after the full hold has elapsed
	hold_before_move_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(level_q != $past(level_q)) |-> ($past(cnt_q) + 16'h0001 >= $past(hold_cycles)))
		else $error("deglitch output moved early");

	// With no hold to wait for, a new level appears on the next edge
	hold_then_pass_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(hold_cycles <= 16'h0001) && (level_in != level_q)
		|=> (level_q == $past(level_in)))
		else $error("deglitch output did not follow");

endmodule : supmon_deglitch

// file: supmon_fault_pick.sv
`timescale 1ns/1ns
// Chooses which comparator result forms the fault
module supmon_fault_pick
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic over_raw,
	input wire logic under_raw,
	input wire logic [1:0] fault_kind_choice,
	output logic pick_q
);

	logic pick_d;

	// Kind 11 is illegal; it raises nothing rather than guess
	always_comb
	begin
		unique case (supmon_pkg::supmon_kind_e'(fault_kind_choice))
			supmon_pkg::KIND_HIGH: pick_d = over_raw;
			supmon_pkg::KIND_LOW: pick_d = under_raw;
			supmon_pkg::KIND_WINDOW: pick_d = over_raw | under_raw;
			supmon_pkg::KIND_BAD: pick_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			pick_q <= 1'b0;
		else
			pick_q <= pick_d;
	end

	window_or_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(fault_kind_choice == 2'h2) && (over_raw || under_raw) |=> pick_q)
		else $error("window fault missed");

endmodule : supmon_fault_pick

// file: supmon_host_model.sv
`timescale 1ns/1ns
// Register host in place of the bus engine; one strobe per access
module supmon_host_model
(
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_ack_q
);
	// Quiet bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// One write; a select byte never carries fault kind 11
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= ((a[2:0] == 3'h4) && (d[1:0] == 2'b11)) ? {d[7:2], 2'b10} : d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // Stale data must not look valid
	endtask : wr

	// One read; data and ack are settled one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ack);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
		ack = reg_ack_q;
	endtask : rd
endmodule : supmon_host_model

// file: supmon_pkg.sv
package supmon_pkg;

	// Register offsets, bipolar monitor A
	localparam logic [7:0] OFS_BIP_A_HIGH_BAND = 8'h00A1;
	localparam logic [7:0] OFS_BIP_A_LOW_LIMIT = 8'h00A2;
	localparam logic [7:0] OFS_BIP_A_LOW_BAND = 8'h00A3;
	localparam logic [7:0] OFS_BIP_A_SELECT = 8'h00A4;
	// Register offsets, bipolar monitor B
	localparam logic [7:0] OFS_BIP_B_HIGH_BAND = 8'h00A9;
	localparam logic [7:0] OFS_BIP_B_LOW_LIMIT = 8'h00AA;
	localparam logic [7:0] OFS_BIP_B_LOW_BAND = 8'h00AB;
	localparam logic [7:0] OFS_BIP_B_SELECT = 8'h00AC;
	// Register offsets, high-voltage monitor
	localparam logic [7:0] OFS_HV_HIGH_LIMIT = 8'h00B0;
	localparam logic [7:0] OFS_HV_HIGH_BAND = 8'h00B1;
	localparam logic [7:0] OFS_HV_LOW_LIMIT = 8'h00B2;
	localparam logic [7:0] OFS_HV_LOW_BAND = 8'h00B3;
	localparam logic [7:0] OFS_HV_SELECT = 8'h00B4;

	// Select register field positions
	localparam int SEL_SIGN_BIT = 7;
	localparam int SEL_DELAY_HI = 6;
	localparam int SEL_DELAY_LO = 4;
	localparam int SEL_SPAN_BIT = 2;
	localparam int SEL_KIND_HI = 1;
	localparam int SEL_KIND_LO = 0;
	localparam int BAND_HI = 4;

	// Power-on values
	localparam logic [7:0] RST_HV_HIGH_LIMIT = 8'h00FF;
	localparam logic [7:0] RST_LOW_LIMIT = 8'h0000;
	localparam logic [4:0] RST_BAND = 5'h00;
	localparam logic [2:0] RST_DELAY = 3'h0;
	localparam logic RST_SIGN = 1'b0;
	localparam logic RST_SPAN = 1'b0;
	localparam logic [1:0] RST_KIND = 2'h0;

	// Timing: clock period in nanoseconds, deglitch delays in microseconds
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	localparam int DLY_US_0 = 0;
	localparam int DLY_US_1 = 5;
	localparam int DLY_US_2 = 10;
	localparam int DLY_US_3 = 20;
	localparam int DLY_US_4 = 30;
	localparam int DLY_US_5 = 50;
	localparam int DLY_US_6 = 75;
	localparam int DLY_US_7 = 100;

	localparam int MON_COUNT = 3;
	localparam int MON_HV = 2;

	typedef enum logic [1:0]
	{
		KIND_HIGH,
		KIND_LOW,
		KIND_WINDOW,
		KIND_BAD
	} supmon_kind_e;

	typedef enum logic [1:0]
	{
		SPAN_1_TO_3,
		SPAN_2_TO_6,
		SPAN_4P8_TO_14P4,
		SPAN_NEG_6_TO_2
	} supmon_span_e;

	// One monitor's programmed setup
	typedef struct packed
	{
		logic [7:0] low_limit_code;
		logic [4:0] high_band_code;
		logic [4:0] low_band_code;
		logic sign_choice;
		logic [2:0] deglitch_delay_choice;
		logic span_choice;
		logic [1:0] fault_kind_choice;
	} supmon_cfg_s;

	// Deglitch delay in cycles for a delay code
	function automatic logic [15:0] supmon_dly_cycles(logic [2:0] code, int cyc_per_us);
		int us;
		unique case (code)
			3'h0: us = DLY_US_0;
			3'h1: us = DLY_US_1;
			3'h2: us = DLY_US_2;
			3'h3: us = DLY_US_3;
			3'h4: us = DLY_US_4;
			3'h5: us = DLY_US_5;
			3'h6: us = DLY_US_6;
			3'h7: us = DLY_US_7;
		endcase
		return 16'(us * cyc_per_us);
	endfunction : supmon_dly_cycles

endpackage : supmon_pkg

// file: supply_monitor_config_regs_tb.sv
`timescale 1ns/1ns
module supply_monitor_config_regs_tb;
	// Short microsecond keeps the longest hold at 200 cycles
	localparam int CPU = 2;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_q, hv_high_limit_q;
	logic reg_wr, reg_rd, reg_ack_q;
	logic [2:0] over_raw = 3'h0;
	logic [2:0] under_raw = 3'h0;
	logic [2:0] fault_q;
	supmon_pkg::supmon_cfg_s cfg_q [supmon_pkg::MON_COUNT];
	supmon_pkg::supmon_span_e span_q [supmon_pkg::MON_COUNT];
	int num_errors = 0;
	int samples_checked = 0;
	logic [7:0] addrs [13] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hB0, 8'hB1, 8'hB2,
		8'hB3, 8'hB4};
	logic [7:0] masks [13] = '{8'h1F, 8'hFF, 8'h1F, 8'hF7, 8'h1F, 8'hFF, 8'h1F, 8'hF7, 8'hFF, 8'h1F, 8'hFF,
		8'h1F, 8'h77};

	always #2 clk_sys = ~clk_sys;

	supmon_config_regs #(.CYC_PER_US(CPU)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.reg_ack_q(reg_ack_q), .over_raw(over_raw), .under_raw(under_raw), .cfg_q(cfg_q),
		.hv_high_limit_q(hv_high_limit_q), .span_q(span_q), .fault_q(fault_q));

	supmon_host_model host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q));

	// Byte comparison, used for every kind of result
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Read one register and compare data and ack
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ack;
		host_u.rd(a, d, ack);
		chk("read data", exp, d);
		chk("read ack", 8'h01, {7'h00, ack});
	endtask : rdchk

	// Power-on values of the whole bank
	task automatic t_reset();
		for (int i = 0; i < 13; i++)
			rdchk(addrs[i], (addrs[i] == supmon_pkg::OFS_HV_HIGH_LIMIT) ? 8'hFF : 8'h00);
		chk("hv limit port", 8'hFF, hv_high_limit_q);
		chk("hv span", 8'(supmon_pkg::SPAN_2_TO_6), 8'(span_q[2]));
	endtask : t_reset

	// All ones written, FE to the selects; reserved bits must read back zero
	task automatic t_mask();
		for (int i = 0; i < 13; i++)
			host_u.wr(addrs[i], (addrs[i][2:0] == 3'h4) ? 8'hFE : 8'hFF);
		chk("cfg low limit", 8'hFF, cfg_q[0].low_limit_code);
		chk("cfg hv band", 8'h1F, {3'h0, cfg_q[2].high_band_code});
		chk("cfg hv sign", 8'h00, {7'h00, cfg_q[2].sign_choice});
		for (int i = 0; i < 13; i++)
			rdchk(addrs[i], ((addrs[i][2:0] == 3'h4) ? 8'hFE : 8'hFF) & masks[i]);
		host_u.wr(8'hA5, 8'hFF);
		rdchk(8'hA5, 8'h00);
		host_u.wr(supmon_pkg::OFS_BIP_B_LOW_LIMIT, 8'h5A);
		rdchk(supmon_pkg::OFS_BIP_B_LOW_LIMIT, 8'h5A);
	endtask : t_mask

	// Range decode; negative sign overrides the span bit
	task automatic t_span();
		logic [7:0] sel [6] = '{8'h80, 8'h84, 8'h04, 8'h00, 8'h04, 8'h00};
		int exp [6] = '{3, 3, 1, 0, 2, 1};
		for (int i = 0; i < 6; i++)
		begin
			host_u.wr((i < 4) ? supmon_pkg::OFS_BIP_A_SELECT : supmon_pkg::OFS_HV_SELECT, sel[i]);
			#1;
			chk("span", 8'(exp[i]), 8'(span_q[(i < 4) ? 0 : 2]));
		end
	endtask : t_span

	// Each legal fault kind against every limit combination, all monitors
	task automatic t_kind();
		logic e;
		for (int k = 0; k < 3; k++)
		begin
			host_u.wr(supmon_pkg::OFS_BIP_A_SELECT, 8'(k));
			host_u.wr(supmon_pkg::OFS_BIP_B_SELECT, 8'(k));
			host_u.wr(supmon_pkg::OFS_HV_SELECT, 8'(k));
			for (int c = 0; c < 4; c++)
			begin
				@(posedge clk_sys);
				over_raw <= {3{c[0]}};
				under_raw <= {3{c[1]}};
				repeat (2) @(posedge clk_sys);
				#1;
				e = (k == 0) ? c[0] : (k == 1) ? c[1] : (c[0] | c[1]);
				chk("fault kind", {5'h00, {3{e}}}, {5'h00, fault_q});
			end
		end
		@(posedge clk_sys);
		under_raw <= 3'h0;
	endtask : t_kind

	// Every delay code: rise seen 1 + hold cycles after the input, 2 cycles for code 0
	task automatic t_delay();
		int us [8] = '{0, 5, 10, 20, 30, 50, 75, 100};
		int n;
		int cnt;
		for (int c = 0; c < 8; c++)
		begin
			host_u.wr(supmon_pkg::OFS_BIP_A_SELECT, {1'b0, 3'(c), 4'h0});
			@(posedge clk_sys);
			over_raw <= 3'h0;
			repeat (205) @(posedge clk_sys);
			over_raw <= 3'h1;
			cnt = 0;
			do
			begin
				@(posedge clk_sys);
				#1;
				cnt++;
			end while (fault_q[0] !== 1'b1 && cnt < 300);
			n = (us[c] == 0) ? 1 : us[c] * CPU;
			chk("delay cycles", 8'(n + 1), 8'(cnt));
		end
	endtask : t_delay

	// Pulse one cycle short of the hold never reaches the output
	task automatic t_glitch();
		int seen = 0;
		host_u.wr(supmon_pkg::OFS_BIP_A_SELECT, 8'h10);
		@(posedge clk_sys);
		over_raw <= 3'h0;
		repeat (15) @(posedge clk_sys);
		over_raw <= 3'h1;
		repeat (9) @(posedge clk_sys);
		over_raw <= 3'h0;
		repeat (20)
		begin
			@(posedge clk_sys);
			#1;
			seen += fault_q[0];
		end
		chk("short pulse", 8'h00, 8'(seen));
	endtask : t_glitch

	// Verdict and end of run
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// Watchdog well beyond the expected run of some 2500 cycles
	initial
	begin
		#100000;
		num_errors++;
		results();
	end

	initial
	begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		t_mask();
		t_span();
		t_kind();
		t_delay();
		t_glitch();
		// Mid-run reset must bring back every power-on value
		arst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset();
		results();
	end
endmodule : supply_monitor_config_regs_tb
